// File: hw/predriver_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 100 MHz clock and byte-wide device registers
`ifndef PREDRIVER_REGS_SVH
`define PREDRIVER_REGS_SVH

// ----------------------------------------------------------------
// Device register offsets
// ----------------------------------------------------------------
`define OFS_POWER_SAVE          8'h10
`define OFS_DRIVE_CONTROL       8'h11
`define OFS_HALL_THRESHOLD      8'h12
`define OFS_ALARM_STATUS_FIRST  8'h13
`define OFS_ALARM_STATUS_SECOND 8'h14
`define OFS_ERROR_WAIT          8'h15
`define OFS_ALARM_PIN_OUTPUT    8'h16
`define OFS_ALARM_OPERATION     8'h17
`define OFS_CURRENT_SENSE_FIRST 8'h18
`define OFS_CURRENT_SENSE_SECOND 8'h19
`define OFS_ADC_SELECT          8'h1a

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define PS_GLOBAL_BIT      0
`define PS_PUMP_REG_BIT    1
`define PS_PUMP_BIT        2
`define PS_GATE_BIT        3
`define PS_HALL_BIT        4
`define DT_ENABLE_BIT      0
`define ALERT_ENABLE_BIT   0
`define SHUTDOWN_BIT       0
`define OC_STATUS_BIT      0
`define TSD_STATUS_BIT     0
`define ADC_SENSE_ROUTE    8'h01
`define GAIN_X50           3'h0
`define GAIN_X25           3'h4
`define GAIN_X8            3'h5
`define REF_SCALE_MAX      2'h2
`define THRESH_CODE_MAX    4'h8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_POWER_SAVE     8'h00
`define RST_DRIVE_CONTROL  8'h01
`define RST_HALL_THRESHOLD 8'h22
`define RST_ALARM_STATUS   8'hff
`define RST_ERROR_WAIT     8'h00
`define RST_ALARM_ENABLE   8'h01
`define RST_SENSE_FIRST    8'h00
`define RST_SENSE_SECOND   8'h00
`define RST_ADC_SELECT     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define DEAD_TIME_NS       200
`define DEAD_CYCLES        ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_WAIT1_NS        1000
`define OC_WAIT2_NS        2000
`define OC_WAIT3_NS        4000
`define OC_WAIT1_CYCLES    ((`OC_WAIT1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_WAIT2_CYCLES    ((`OC_WAIT2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_WAIT3_CYCLES    ((`OC_WAIT3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_LATENCY       2

`endif

// File: hw/predriver_pkg.sv
// Types shared by the two ends of the pre-driver link
// Assumes nothing beyond the constants header
package predriver_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] gate_t;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_WRITE = 2'b01,
    H_READ1 = 2'b10,
    H_READ2 = 2'b11
  } host_state_e;
endpackage : predriver_pkg

// File: hw/predriver_link.sv
// Link between the pre-driver control logic and the host controller
// Assumes both ends share clk; the bench joins the modports
interface predriver_link;
  import predriver_pkg::*;
  reg_byte_t reg_addr;
  reg_byte_t reg_wdata;
  logic      reg_wr;
  reg_byte_t reg_rdata;
  gate_t     gate_in;
  logic [2:0] hall_out;
  logic      alarm_n;

  modport device_end (
    input  reg_addr, reg_wdata, reg_wr, gate_in,
    output reg_rdata, hall_out, alarm_n
  );
  modport host_end (
    output reg_addr, reg_wdata, reg_wr, gate_in,
    input  reg_rdata, hall_out, alarm_n
  );
endinterface : predriver_link

// File: hw/predriver_protect_control.sv
// Pre-driver control: power save gating, dead time, Hall pass-through,
// overcurrent and thermal protection with latched active-low status.
// Assumes analog front ends deliver comparator levels asynchronously.
//
// The placing of the registers and the APB register port were left to the implementer.
`include "predriver_regs.svh"

// Notes on behaviour
// - Host releases four power saves before driving
// - Host changes gate inputs after gate release
// - Enable bit switches automatic dead-time insertion
// - Host keeps dead-time adjustment enabled
// - Select pin low picks internal regulator
// - Thermal shutdown stops regulator until cooled
// - Regulator overcurrent folds back, no status
// - Three Hall channels passed to host
// - Host releases global and Hall saves first
// - Hall register holds threshold and hysteresis
// - Error latched in status, alarm pin low
// - Errors stop driving external MOSFETs
// - Detection needs related power save released
// - Overcurrent flagged after full wait time
// - Reset wait field selects no wait
// - Alert enable pulls alarm low on overcurrent
// - Shutdown enable forces all gate outputs low
// - Selector 0x01 routes sense amp to channel seven
// - Gain, scale, attenuation, threshold code fields
module predriver_protect_control
  import predriver_pkg::*;
#(
  parameter int DEAD_CYCLES = `DEAD_CYCLES
)(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  predriver_link.device_end link,
  input  wire logic [2:0]   hall_raw,
  input  wire logic         overcurrent_raw,
  input  wire logic         thermal_shutdown,
  input  wire logic         regulator_overcurrent,
  input  wire logic         regulator_source_select,
  output logic [5:0]        gate_out,
  output logic              internal_regulator_on,
  output logic              foldback_limit,
  output logic              hall_comparator_on,
  output logic [2:0]        hall_threshold_code,
  output logic [1:0]        hall_hysteresis_code,
  output logic [2:0]        shunt_gain,
  output logic [1:0]        sense_reference_scale,
  output logic              sense_attenuation_bit,
  output logic [3:0]        overcurrent_threshold_code,
  output logic              analog_channel_seven
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg_byte_t  power_save;
  reg_byte_t  drive_control;
  reg_byte_t  hall_threshold_setting;
  reg_byte_t  alarm_status_first;
  reg_byte_t  alarm_status_second;
  reg_byte_t  error_wait;
  reg_byte_t  alarm_pin_output_setting;
  reg_byte_t  alarm_operation_setting;
  reg_byte_t  current_sense_setting_first;
  reg_byte_t  current_sense_setting_second;
  reg_byte_t  adc_select;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt;

  assign async_in = {regulator_source_select, regulator_overcurrent,
                     thermal_shutdown, overcurrent_raw, hall_raw};

  // A bit moves only once the second and third stages agree
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt  <= '0;
    end
    else if (ce)
    begin
      sync1 <= async_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (filt & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
    end

  logic [2:0] hall_f;
  logic       oc_f;
  logic       tsd_f;
  logic       regoc_f;
  logic       regsel_f;
  assign hall_f   = filt[2:0];
  assign oc_f     = filt[3];
  assign tsd_f    = filt[4];
  assign regoc_f  = filt[5];
  assign regsel_f = filt[6];

  // ----------------------------------------------------------------
  // Power save decode
  // ----------------------------------------------------------------
  logic global_power_save_release;
  logic pump_regulator_power_save_release;
  logic pump_power_save_release;
  logic gate_driver_power_save_release;
  logic hall_power_save_release;
  logic gate_active;
  logic oc_detect_on;

  assign global_power_save_release         = power_save[`PS_GLOBAL_BIT];
  assign pump_regulator_power_save_release = power_save[`PS_PUMP_REG_BIT];
  assign pump_power_save_release           = power_save[`PS_PUMP_BIT];
  assign gate_driver_power_save_release    = power_save[`PS_GATE_BIT];
  assign hall_power_save_release           = power_save[`PS_HALL_BIT];
  // Driver stays dead while any of the four saves is still on
  assign gate_active = global_power_save_release & pump_regulator_power_save_release
                     & pump_power_save_release & gate_driver_power_save_release;
  // Overcurrent sensing belongs to the driver function
  assign oc_detect_on = global_power_save_release & gate_driver_power_save_release;
  assign hall_comparator_on = global_power_save_release & hall_power_save_release;

  // ----------------------------------------------------------------
  // Overcurrent qualification
  // ----------------------------------------------------------------
  logic [8:0] oc_count;
  logic [8:0] oc_target;
  logic       oc_event;
  logic       tsd_event;

  // Reset field value 0 gives a zero target, so the flag is immediate
  always_comb
    unique case (error_wait[1:0])
      2'h0:    oc_target = 9'h000;
      2'h1:    oc_target = 9'(`OC_WAIT1_CYCLES);
      2'h2:    oc_target = 9'(`OC_WAIT2_CYCLES);
      2'h3:    oc_target = 9'(`OC_WAIT3_CYCLES);
    endcase

  // Any drop of the comparator restarts the wait
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      oc_count <= '0;
    else if (ce)
    begin
      if (!(oc_f && oc_detect_on))
        oc_count <= '0;
      else if (oc_count != oc_target)
        oc_count <= oc_count + 9'h001;
    end

  assign oc_event  = oc_f && oc_detect_on && (oc_count == oc_target);
  assign tsd_event = tsd_f && global_power_save_release;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic wr_status1;
  logic wr_status2;
  assign wr_status1 = link.reg_wr && (link.reg_addr == `OFS_ALARM_STATUS_FIRST);
  assign wr_status2 = link.reg_wr && (link.reg_addr == `OFS_ALARM_STATUS_SECOND);

  // Control registers; illegal sense codes keep the old field
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      power_save                   <= `RST_POWER_SAVE;
      drive_control                <= `RST_DRIVE_CONTROL;
      hall_threshold_setting       <= `RST_HALL_THRESHOLD;
      error_wait                   <= `RST_ERROR_WAIT;
      alarm_pin_output_setting     <= `RST_ALARM_ENABLE;
      alarm_operation_setting      <= `RST_ALARM_ENABLE;
      current_sense_setting_first  <= `RST_SENSE_FIRST;
      current_sense_setting_second <= `RST_SENSE_SECOND;
      adc_select                   <= `RST_ADC_SELECT;
    end
    else if (ce && link.reg_wr)
      unique case (link.reg_addr)
        `OFS_POWER_SAVE:       power_save <= link.reg_wdata;
        `OFS_DRIVE_CONTROL:    drive_control <= link.reg_wdata;
        `OFS_HALL_THRESHOLD:   hall_threshold_setting <= link.reg_wdata;
        `OFS_ERROR_WAIT:       error_wait <= link.reg_wdata;
        `OFS_ALARM_PIN_OUTPUT: alarm_pin_output_setting <= link.reg_wdata;
        `OFS_ALARM_OPERATION:  alarm_operation_setting <= link.reg_wdata;
        `OFS_CURRENT_SENSE_FIRST:
        begin
          if (link.reg_wdata[2:0] == `GAIN_X50 || link.reg_wdata[2:0] == `GAIN_X25
              || link.reg_wdata[2:0] == `GAIN_X8)
            current_sense_setting_first[2:0] <= link.reg_wdata[2:0];
          if (link.reg_wdata[7:4] <= `THRESH_CODE_MAX)
            current_sense_setting_first[7:4] <= link.reg_wdata[7:4];
        end
        `OFS_CURRENT_SENSE_SECOND:
        begin
          if (link.reg_wdata[1:0] <= `REF_SCALE_MAX)
            current_sense_setting_second[1:0] <= link.reg_wdata[1:0];
          current_sense_setting_second[2] <= link.reg_wdata[2];
        end
        `OFS_ADC_SELECT:       adc_select <= link.reg_wdata;
        default:               ;
      endcase

  // ----------------------------------------------------------------
  // Alarm status, active low, write one to rearm
  // ----------------------------------------------------------------
  // A detection in the rearm cycle wins, so no event is lost
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      alarm_status_first  <= `RST_ALARM_STATUS;
      alarm_status_second <= `RST_ALARM_STATUS;
    end
    else if (ce)
    begin
      if (oc_event)
        alarm_status_first[`OC_STATUS_BIT] <= 1'b0;
      else if (wr_status1 && link.reg_wdata[`OC_STATUS_BIT])
        alarm_status_first[`OC_STATUS_BIT] <= 1'b1;
      if (tsd_event)
        alarm_status_second[`TSD_STATUS_BIT] <= 1'b0;
      else if (wr_status2 && link.reg_wdata[`TSD_STATUS_BIT])
        alarm_status_second[`TSD_STATUS_BIT] <= 1'b1;
    end

  logic overcurrent_status_low;
  logic oc_flag;
  logic tsd_flag;
  logic protect_stop;
  assign overcurrent_status_low = alarm_status_first[`OC_STATUS_BIT];
  assign oc_flag  = !overcurrent_status_low;
  assign tsd_flag = !alarm_status_second[`TSD_STATUS_BIT];
  assign protect_stop = (oc_flag && alarm_operation_setting[`SHUTDOWN_BIT])
                      || tsd_flag;

  // ----------------------------------------------------------------
  // Read data, alarm pin and Hall outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      link.reg_rdata <= '0;
      link.alarm_n   <= 1'b1;
      link.hall_out  <= '0;
    end
    else if (ce)
    begin
      unique case (link.reg_addr)
        `OFS_POWER_SAVE:           link.reg_rdata <= power_save;
        `OFS_DRIVE_CONTROL:        link.reg_rdata <= drive_control;
        `OFS_HALL_THRESHOLD:       link.reg_rdata <= hall_threshold_setting;
        `OFS_ALARM_STATUS_FIRST:   link.reg_rdata <= alarm_status_first;
        `OFS_ALARM_STATUS_SECOND:  link.reg_rdata <= alarm_status_second;
        `OFS_ERROR_WAIT:           link.reg_rdata <= error_wait;
        `OFS_ALARM_PIN_OUTPUT:     link.reg_rdata <= alarm_pin_output_setting;
        `OFS_ALARM_OPERATION:      link.reg_rdata <= alarm_operation_setting;
        `OFS_CURRENT_SENSE_FIRST:  link.reg_rdata <= current_sense_setting_first;
        `OFS_CURRENT_SENSE_SECOND: link.reg_rdata <= current_sense_setting_second;
        `OFS_ADC_SELECT:           link.reg_rdata <= adc_select;
        default:                   link.reg_rdata <= '0;
      endcase
      link.alarm_n <= !((oc_flag && alarm_pin_output_setting[`ALERT_ENABLE_BIT])
                        || tsd_flag);
      link.hall_out <= hall_f & {3{hall_comparator_on}};
    end

  // ----------------------------------------------------------------
  // Gate outputs with dead-time insertion
  // ----------------------------------------------------------------
  // Each output waits until its partner has been off for DEAD_CYCLES;
  // inputs that already carry that gap pass through unchanged
  logic       dt_enable;
  logic [5:0] next_gate_out;
  logic [7:0] off_count [6];
  assign dt_enable = drive_control[`DT_ENABLE_BIT];

  for (genvar i = 0; i < 6; i++)
  begin : g_gate
    localparam int P = i ^ 1;
    assign next_gate_out[i] = gate_active && !protect_stop
                           && link.gate_in[i] && !link.gate_in[P] && !gate_out[P]
                           && (!dt_enable || off_count[P] >= 8'(DEAD_CYCLES));

    // Counts how long this output has been off, saturating
    always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
        off_count[i] <= 8'(DEAD_CYCLES);
      else if (ce)
      begin
        if (gate_out[i])
          off_count[i] <= '0;
        else if (off_count[i] < 8'(DEAD_CYCLES))
          off_count[i] <= off_count[i] + 8'h01;
      end
  end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      gate_out <= '0;
    else if (ce)
      gate_out <= next_gate_out;

  // ----------------------------------------------------------------
  // Analog settings
  // ----------------------------------------------------------------
  assign internal_regulator_on      = !regsel_f && !tsd_f;
  assign foldback_limit             = regoc_f;
  assign hall_threshold_code        = hall_threshold_setting[2:0];
  assign hall_hysteresis_code       = hall_threshold_setting[5:4];
  assign shunt_gain                 = current_sense_setting_first[2:0];
  assign overcurrent_threshold_code = current_sense_setting_first[7:4];
  assign sense_reference_scale      = current_sense_setting_second[1:0];
  assign sense_attenuation_bit      = current_sense_setting_second[2];
  assign analog_channel_seven       = (adc_select == `ADC_SENSE_ROUTE);

endmodule : predriver_protect_control

// File: hw/predriver_host_ctrl.sv
// Host end: APB slave whose registers order device register accesses
// and set the gate inputs. Assumes the device answers reads in 2 cycles.
`include "predriver_regs.svh"

module predriver_host_ctrl
  import predriver_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  predriver_link.host_end   link,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr
);

  // ----------------------------------------------------------------
  // Own register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_COMMAND = 8'h00;
  localparam logic [7:0] A_CONTROL = 8'h04;
  localparam logic [7:0] A_STATUS  = 8'h08;
  localparam logic [7:0] A_GATE    = 8'h0c;

  host_state_e state;
  reg_byte_t   cmd_addr;
  reg_byte_t   cmd_data;
  reg_byte_t   read_data;
  gate_t       gate_req;
  reg_byte_t   ps_shadow;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic        gate_allowed;
  logic        hall_allowed;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;
  assign mapped = (paddr == A_COMMAND) || (paddr == A_CONTROL)
               || (paddr == A_STATUS) || (paddr == A_GATE);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Gate and Hall use follows the power saves this host has released
  assign gate_allowed = ps_shadow[`PS_GLOBAL_BIT] && ps_shadow[`PS_PUMP_REG_BIT]
                     && ps_shadow[`PS_PUMP_BIT] && ps_shadow[`PS_GATE_BIT];
  assign hall_allowed = ps_shadow[`PS_GLOBAL_BIT] && ps_shadow[`PS_HALL_BIT];

  // ----------------------------------------------------------------
  // APB writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cmd_addr <= '0;
      cmd_data <= '0;
      gate_req <= '0;
    end
    else if (ce && wr_en)
    begin
      if (paddr == A_COMMAND && state == H_IDLE)
      begin
        cmd_data <= pwdata[7:0];
        cmd_addr <= pwdata[15:8];
      end
      if (paddr == A_GATE)
        gate_req <= pwdata[5:0];
    end

  // ----------------------------------------------------------------
  // Device access sequencer
  // ----------------------------------------------------------------
  // Starts are ignored while busy, so a command is never torn
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      state     <= H_IDLE;
      read_data <= '0;
      ps_shadow <= `RST_POWER_SAVE;
    end
    else if (ce)
      unique case (state)
        H_IDLE:
          if (wr_en && paddr == A_CONTROL && pwpending(pwdata))
            state <= pwdata[1] ? H_READ1 : H_WRITE;
        H_WRITE:
        begin
          if (cmd_addr == `OFS_POWER_SAVE)
            ps_shadow <= cmd_data;
          state <= H_IDLE;
        end
        H_READ1: state <= H_READ2;
        H_READ2:
        begin
          read_data <= link.reg_rdata;
          state     <= H_IDLE;
        end
      endcase

  function automatic logic pwpending(input logic [31:0] d);
    pwpending = d[0];
  endfunction : pwpending

  // ----------------------------------------------------------------
  // Link drive and APB read data
  // ----------------------------------------------------------------
  assign link.reg_addr = cmd_addr;
  assign link.reg_wr   = (state == H_WRITE);
  // Dead-time adjustment is always kept on for safety
  assign link.reg_wdata = (cmd_addr == `OFS_DRIVE_CONTROL)
                        ? (cmd_data | 8'(1 << `DT_ENABLE_BIT)) : cmd_data;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      link.gate_in <= '0;
    else if (ce)
      link.gate_in <= gate_allowed ? gate_req : 6'h00;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      prdata <= '0;
    else if (ce && setup)
      unique case (paddr)
        A_COMMAND: prdata <= {16'h0000, cmd_addr, cmd_data};
        A_STATUS:  prdata <= {16'h0000, read_data, 3'h0,
                              hall_allowed ? link.hall_out : 3'h0,
                              link.alarm_n, state != H_IDLE};
        A_GATE:    prdata <= {26'h0000000, gate_req};
        default:   prdata <= '0;
      endcase

endmodule : predriver_host_ctrl

// File: tb/predriver_protect_control_chk.sv
// Assertions on the link between host end and device end
// Assumes each input is wired to the link signal of that name
module predriver_protect_control_chk
  import predriver_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire reg_byte_t  reg_addr,
  input wire reg_byte_t  reg_wdata,
  input wire logic       reg_wr,
  input wire reg_byte_t  reg_rdata,
  input wire gate_t      gate_in,
  input wire logic [2:0] hall_out,
  input wire logic       alarm_n
);
  logic [4:0] saves;
  logic       glob_seen, gate_seen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Two edges with no write that could rearm it, alarm low at the second
  sequence s_quiet_low;
    !reg_wr ##1 (!reg_wr && !alarm_n);
  endsequence
  // Power save shadow, taken at the edge the device takes it
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      {saves, glob_seen, gate_seen} <= '0;
    else if (reg_wr && reg_addr == 8'h10)
      {saves, glob_seen, gate_seen} <=
        {reg_wdata[4:0], glob_seen | reg_wdata[0], gate_seen | (&reg_wdata[3:0])};
  a_alarm_after_reset: assert property ($rose(rst_b) |-> alarm_n)
    else $error("alarm low");
  a_unmapped_zero: assert property (!(reg_addr inside {[8'h10:8'h1a]}) |=> !reg_rdata)
    else $error("unmapped read");
  a_hall_gated: assert property ((!saves[0] || !saves[4]) [*2] |-> !hall_out)
    else $error("hall while saved");
  a_alarm_needs_global: assert property (!glob_seen |=> alarm_n)
    else $error("early alarm");
  a_gate_after_release: assert property (gate_in != 6'h00 |-> gate_seen)
    else $error("early gate");
  a_dead_time_kept: assert property (reg_wr && reg_addr == 8'h11 |-> reg_wdata[0])
    else $error("dead time off");
  a_strobe_single: assert property (reg_wr |=> !reg_wr)
    else $error("long strobe");
  a_alarm_latched: assert property (s_quiet_low |=> !alarm_n)
    else $error("alarm released");
endmodule : predriver_protect_control_chk

// File: tb/predriver_protect_control_tb_top.sv
// Bench joining host end and device end, driven over APB
// Assumes design files and checker are compiled first
module predriver_protect_control_tb_top;
  timeunit 1ns / 1ns;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  hall_raw = 3'h5, hall_threshold_code, shunt_gain;
  logic [1:0]  hall_hysteresis_code, sense_reference_scale;
  logic [3:0]  overcurrent_threshold_code;
  logic [5:0]  gate_out;
  logic        overcurrent_raw = 0, thermal_shutdown = 0, regulator_overcurrent = 1;
  logic        regulator_source_select = 0, internal_regulator_on, foldback_limit;
  logic        hall_comparator_on, sense_attenuation_bit, analog_channel_seven;
  int          bad_count = 0, num_checks = 0;
  predriver_link link ();
  predriver_host_ctrl predriver_host_ctrl_inst (.ce(1'b1), .link(link.host_end), .*);
  // Short dead time keeps the run brief
  predriver_protect_control #(.DEAD_CYCLES(2)) predriver_protect_control_inst (.ce(1'b1),
    .link(link.device_end), .*);
  predriver_protect_control_chk predriver_protect_control_chk_inst (.clk, .rst_b,
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rdata(link.reg_rdata), .gate_in(link.gate_in), .hall_out(link.hall_out),
    .alarm_n(link.alarm_n));
  always #5 clk = ~clk;
  task automatic check(input logic [31:0] seen, want);
    num_checks++;
    bad_count += (seen !== want);
    if (seen !== want) $display("wrong value %0t: %h not %h", $time, seen, want);
  endtask : check
  task automatic print_verdict(input int hung);
    bad_count += hung;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // One APB transfer, held until pready; a stuck slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n > 49) print_verdict(1);
    @(posedge clk);
  endtask : apb
  // Device access through the host; polls busy, last read lands in rd[15:8]
  task automatic dev(input logic [7:0] a, d, input logic r);
    int k = 0;
    apb(1, 8'h00, {16'h0, a, d});
    apb(1, 8'h04, {30'h0, r, 1'b1});
    do apb(0, 8'h08, 0); while (rd[0] !== 1'b0 && ++k < 50);
    if (k > 49) print_verdict(1);
  endtask : dev
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    dev(8'h15, 8'h00, 1);
    check(rd[15:8], 8'h00);
    dev(8'h13, 8'h00, 1);
    check({rd[15:8], rd[4:1], foldback_limit, hall_threshold_code, hall_hysteresis_code},
      18'h3fc6a);
    dev(8'h10, 8'h11, 0);
    dev(8'h1a, 8'h01, 0);
    dev(8'h18, 8'h85, 0);
    dev(8'h18, 8'h93, 0);
    check({rd[4:2], analog_channel_seven, shunt_gain, overcurrent_threshold_code},
      11'h5d8);
    dev(8'h19, 8'h07, 0);
    check({sense_reference_scale, sense_attenuation_bit, hall_comparator_on}, 4'h3);
    apb(0, 8'h10, 0);
    check({err, rd}, 33'h100000000); // Unmapped host offset
    regulator_source_select <= 1;
    dev(8'h11, 8'h00, 0);
    dev(8'h10, 8'h1f, 0);
    dev(8'h15, 8'h01, 0);
    check(internal_regulator_on, 0);
    apb(1, 8'h0c, 32'h3);
    repeat (8) @(posedge clk);
    check(gate_out, 6'h00);
    apb(1, 8'h0c, 32'h1);
    overcurrent_raw <= 1;
    repeat (50) @(posedge clk);
    check({gate_out, link.alarm_n}, 7'h03);
    repeat (70) @(posedge clk);
    check({gate_out, link.alarm_n}, 7'h00);
    {thermal_shutdown, regulator_source_select} <= 2'b10;
    dev(8'h14, 8'h00, 1);
    check({rd[8], rd[1], internal_regulator_on}, 3'h0);
    thermal_shutdown <= 0;
    repeat (8) @(posedge clk);
    check(internal_regulator_on, 1);
    print_verdict(0);
  end
endmodule : predriver_protect_control_tb_top
